// ### eprc_pkg.sv
// Package with shared constants, states and carriers of the memory programmer controller.
package eprc_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned PULSE_NOM_US    = 100;
  localparam int unsigned PULSE_MIN_US    = 95;
  localparam int unsigned PULSE_MAX_US    = 105;
  localparam int unsigned PULSE_CYC       = (PULSE_NOM_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_US        = 2;
  localparam int unsigned SETUP_CYC       = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_NS       = 250;
  localparam int unsigned ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GATE_ACCESS_NS  = 150;
  localparam int unsigned GATE_ACCESS_CYC = (GATE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLOAT_NS        = 130;
  localparam int unsigned FLOAT_CYC       = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAX_RETRY       = 10;
  localparam int unsigned ADDR_W          = 18;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned ID_LINE_BIT     = 9;

  typedef enum logic [1:0]
  {
    EPRC_OP_READ  = 2'b00,
    EPRC_OP_ID    = 2'b01,
    EPRC_OP_PROG  = 2'b10
  } eprc_op_t;

  typedef enum logic [1:0]
  {
    EPRC_SUP_READ  = 2'b00,
    EPRC_SUP_RAISE = 2'b01,
    EPRC_SUP_PROG  = 2'b10
  } eprc_sup_t;

  typedef struct packed
  {
    logic              chip_sel_n;
    logic              gate_n;
    logic              program_strobe_n;
    logic              id_high_volt;
    logic [ADDR_W-1:0] addr;
  } eprc_pins_t;

endpackage : eprc_pkg

// ### eprc_timer.sv
// Down-counting delay timer used for pulse widths, setup and access waits.
module eprc_timer
  import eprc_pkg::*;
#(
  parameter int unsigned CNT_W = 13
)
(
  input  wire logic             mclk_i,   // System clock.
  input  wire logic             reset_i,  // Synchronous reset, active high.
  input  wire logic             load_i,   // Load a new count.
  input  wire logic [CNT_W-1:0] count_i,  // Cycles to wait.
  output logic                  done_o    // High once the count has run out.
);

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      cnt_q <= '0;
    else if (load_i)
      cnt_q <= count_i;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  // Done looks at the count only, so a load that depends on done closes no combinational loop.
  assign done_o = (cnt_q == '0);

endmodule : eprc_timer

// ### eprc_pulse_cnt.sv
// Counter of extra program pulses given to one byte.
module eprc_pulse_cnt
  import eprc_pkg::*;
#(
  parameter int unsigned LIMIT = MAX_RETRY
)
(
  input  wire logic       mclk_i,   // System clock.
  input  wire logic       reset_i,  // Synchronous reset, active high.
  input  wire logic       clear_i,  // Restart count for a new byte.
  input  wire logic       incr_i,   // One more pulse issued.
  output logic [3:0]      count_o,  // Pulses so far.
  output logic            limit_o   // Limit of pulses reached.
);

  logic [3:0] count_q;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i || clear_i)
      count_q <= 4'h0;
    else if (incr_i && count_q != 4'(LIMIT))
      count_q <= count_q + 4'h1;
  end

  assign count_o = count_q;
  assign limit_o = (count_q == 4'(LIMIT));

endmodule : eprc_pulse_cnt

// ### eprc_ctrl.sv
// Controller that reads, identifies and programs a byte-wide UV-erasable memory.
// Operation
// - Hold the program strobe low about 100 us, within 95 to 105 us.
// - Select first address, then raise core to 6.5 V, programming supply to 13 V.
// - First pass gives every address one pulse and no verify.
// - Second pass verifies each byte; mismatches get up to ten pulses, verifying each.
// - A byte failing after ten extra pulses stops the run as failed.
// - A verified byte moves on to the next address until all checked.
// - Then drop both supplies to 5 V and compare every byte with source.
// - Core supply rises no later and falls no earlier than programming supply.
// - Gate may lag chip select by chip-select minus gate access time.
// - Gate may lag address by address access minus gate access time.
// - Wait 130 ns float time after gate rises before driving data.
// - Verify reads wait the gate access time before sampling data.
// - Identification holds addresses low, high voltage on line nine, toggles line zero.
module eprc_ctrl
  import eprc_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC,
  parameter int unsigned AW           = ADDR_W,
  parameter logic [AW-1:0] LAST_ADDR  = '1
)
(
  input  wire logic                 mclk_i,        // 40 MHz clock.
  input  wire logic                 reset_i,       // Synchronous reset, active high.
  input  wire logic                 req_valid_i,   // Request strobe.
  input  wire eprc_pkg::eprc_op_t   req_op_i,      // Read, identify or program.
  input  wire logic [AW-1:0]        req_addr_i,    // Address for read; id byte in bit 0.
  output logic                      req_ready_o,   // Controller idle.
  output logic                      rsp_valid_o,   // One-cycle answer pulse.
  output logic [DATA_W-1:0]         rsp_data_o,    // Read or id byte.
  output logic                      rsp_fail_o,    // Program run failed.
  output logic [AW-1:0]             src_addr_o,    // Address of source byte wanted.
  input  wire logic [DATA_W-1:0]    src_data_i,    // Source byte for src_addr_o.
  output logic [AW-1:0]             mem_addr_o,    // Memory address lines.
  output logic                      chip_sel_n_o,  // Chip select, active low.
  output logic                      gate_n_o,      // Output gate, active low.
  output logic                      program_strobe_n_o, // Program strobe, active low.
  output logic                      id_high_volt_o,// High voltage on id select line.
  output eprc_pkg::eprc_sup_t       supply_o,      // Supply level request.
  input  wire logic [DATA_W-1:0]    data_in_i,     // Data lines as read.
  output logic [DATA_W-1:0]         data_out_o,    // Data lines as driven.
  output logic                      data_oe_n_o    // Low while driving data lines.
);

  typedef enum logic [3:0]
  {
    ST_IDLE   = 4'b0000,
    ST_RD     = 4'b0001,
    ST_RDDONE = 4'b0010,
    ST_SUPUP  = 4'b0011,
    ST_PSET   = 4'b0100,
    ST_PULSE  = 4'b0101,
    ST_PHOLD  = 4'b0110,
    ST_VGATE  = 4'b0111,
    ST_VSAMP  = 4'b1000,
    ST_FLOAT  = 4'b1001,
    ST_SUPDN  = 4'b1010,
    ST_CHK    = 4'b1011,
    ST_FIN    = 4'b1100
  } eprc_state_t;

  localparam int unsigned TW = $clog2(PULSE_CYCLES + 1) + 1;

  eprc_state_t       state_q;
  eprc_op_t          op_q;
  eprc_pins_t        pins_q;
  eprc_sup_t         sup_q;
  logic              pass2_q;
  logic              fail_q;
  logic              pulsed_q;
  logic [DATA_W-1:0] dout_q;
  logic              doe_n_q;
  logic              rsp_valid_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic              tload;
  logic [TW-1:0]     tcount;
  logic              tdone;
  logic              pc_clear;
  logic              pc_incr;
  logic              pc_limit;

  function automatic logic [TW-1:0] cyc(input int unsigned n);
    cyc = TW'(n);
  endfunction : cyc

  ////////////////////////////////////////////////////////////////////////////////

  eprc_timer #(.CNT_W(TW)) u_timer
  (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .load_i  (tload),
    .count_i (tcount),
    .done_o  (tdone)
  );

  eprc_pulse_cnt #(.LIMIT(MAX_RETRY)) u_pcnt
  (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .clear_i (pc_clear),
    .incr_i  (pc_incr),
    .count_o (),
    .limit_o (pc_limit)
  );

  // Timer loads come from the state register so each wait starts on entry, except the ST_FIN byte waits, which start as the address steps.
  always_comb
  begin
    tload    = 1'b0;
    tcount   = '0;
    pc_clear = 1'b0;
    pc_incr  = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (req_valid_i)
        begin
          tload  = 1'b1;
          tcount = (req_op_i == EPRC_OP_PROG) ? cyc(SETUP_CYC) : cyc(ACCESS_CYC);
          pc_clear = 1'b1;
        end
      end
      ST_SUPUP:
      begin
        if (tdone)
        begin
          tload  = 1'b1;
          tcount = cyc(SETUP_CYC);
        end
      end
      ST_PSET:
      begin
        if (tdone)
        begin
          tload  = 1'b1;
          tcount = cyc(PULSE_CYCLES);
          pc_incr = pass2_q;
        end
      end
      ST_PULSE:
      begin
        if (tdone)
        begin
          tload  = 1'b1;
          tcount = cyc(SETUP_CYC);
        end
      end
      ST_PHOLD, ST_FLOAT:
      begin
        if (tdone)
        begin
          tload  = 1'b1;
          tcount = (state_q == ST_PHOLD && pass2_q) ? cyc(GATE_ACCESS_CYC) : cyc(SETUP_CYC);
        end
      end
      ST_VSAMP:
      begin
        tload  = 1'b1;
        tcount = cyc(FLOAT_CYC);
        pc_clear = (data_in_i == src_data_i);
      end
      ST_SUPDN:
      begin
        if (tdone)
        begin
          tload  = 1'b1;
          tcount = cyc(ACCESS_CYC);
        end
      end
      ST_CHK:
      begin
        if (tdone)
        begin
          tload  = 1'b1;
          tcount = cyc(SETUP_CYC);
        end
      end
      ST_FIN:
      begin
        // Each read-back byte gets a fresh access wait after its address steps.
        if (!fail_q && !pins_q.chip_sel_n && !pulsed_q && tdone)
        begin
          tload  = 1'b1;
          tcount = cyc(ACCESS_CYC);
        end
      end
      default:
      begin
        tload = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Sequencer for all operations.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_q     <= ST_IDLE;
      op_q        <= EPRC_OP_READ;
      pins_q      <= '{chip_sel_n: 1'b1, gate_n: 1'b1, program_strobe_n: 1'b1, id_high_volt: 1'b0, addr: '0};
      sup_q       <= EPRC_SUP_READ;
      pass2_q     <= 1'b0;
      fail_q      <= 1'b0;
      pulsed_q    <= 1'b0;
      dout_q      <= '0;
      doe_n_q     <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (req_valid_i)
          begin
            op_q   <= req_op_i;
            fail_q <= 1'b0;
            if (req_op_i == EPRC_OP_PROG)
            begin
              pins_q.addr <= '0;
              pass2_q     <= 1'b0;
              state_q     <= ST_SUPUP;
            end
            else
            begin
              // Both selects drop with the address, so gate lag is zero.
              pins_q.chip_sel_n <= 1'b0;
              pins_q.gate_n     <= 1'b0;
              if (req_op_i == EPRC_OP_ID)
              begin
                pins_q.addr         <= AW'(req_addr_i[0]);
                pins_q.id_high_volt <= 1'b1;
              end
              else
                pins_q.addr <= req_addr_i;
              state_q <= ST_RD;
            end
          end
        end
        ST_RD:
        begin
          if (tdone)
          begin
            rsp_data_q        <= data_in_i;
            pins_q.chip_sel_n <= 1'b1;
            pins_q.gate_n     <= 1'b1;
            state_q           <= ST_RDDONE;
          end
        end
        ST_RDDONE:
        begin
          // Id voltage comes off only after the selects are released.
          pins_q.id_high_volt <= 1'b0;
          rsp_valid_q         <= 1'b1;
          state_q             <= ST_IDLE;
        end
        ST_SUPUP:
        begin
          // Core supply goes up first; programming supply follows a setup later.
          if (sup_q == EPRC_SUP_READ)
            sup_q <= EPRC_SUP_RAISE;
          else if (tdone)
          begin
            sup_q             <= EPRC_SUP_PROG;
            pins_q.chip_sel_n <= 1'b0;
            dout_q            <= src_data_i;
            doe_n_q           <= 1'b0;
            state_q           <= ST_PSET;
          end
        end
        ST_PSET:
        begin
          if (tdone)
          begin
            pins_q.program_strobe_n <= 1'b0;
            state_q                 <= ST_PULSE;
          end
        end
        ST_PULSE:
        begin
          if (tdone)
          begin
            pins_q.program_strobe_n <= 1'b1;
            state_q                 <= ST_PHOLD;
          end
        end
        ST_PHOLD:
        begin
          if (tdone)
          begin
            if (!pass2_q)
            begin
              // One blind pulse per address in the first pass.
              if (pins_q.addr == LAST_ADDR)
              begin
                pass2_q     <= 1'b1;
                pins_q.addr <= '0;
                doe_n_q     <= 1'b1;
                pulsed_q    <= 1'b0;
                state_q     <= ST_FLOAT;
              end
              else
              begin
                pins_q.addr <= pins_q.addr + 1'b1;
                state_q     <= ST_FLOAT;
              end
            end
            else
            begin
              doe_n_q       <= 1'b1;
              pins_q.gate_n <= 1'b0;
              state_q       <= ST_VGATE;
            end
          end
        end
        ST_FLOAT:
        begin
          // Next byte of pass one, or start a pass-two verify with data lines free.
          if (tdone)
          begin
            if (!pass2_q)
            begin
              dout_q  <= src_data_i;
              doe_n_q <= 1'b0;
              state_q <= ST_PSET;
            end
            else
            begin
              pins_q.gate_n <= 1'b0;
              state_q       <= ST_VGATE;
            end
          end
        end
        ST_VGATE:
        begin
          if (tdone)
            state_q <= ST_VSAMP;
        end
        ST_VSAMP:
        begin
          pins_q.gate_n <= 1'b1;
          if (data_in_i == src_data_i)
          begin
            if (pins_q.addr == LAST_ADDR)
            begin
              state_q <= ST_SUPDN;
            end
            else
            begin
              pins_q.addr <= pins_q.addr + 1'b1;
              state_q     <= ST_FLOAT;
            end
          end
          else if (pc_limit)
          begin
            fail_q  <= 1'b1;
            state_q <= ST_FIN;
          end
          else
          begin
            dout_q  <= src_data_i;
            state_q <= ST_CHK;
          end
        end
        ST_CHK:
        begin
          // Gate is back up; wait out the float before driving data again.
          if (tdone)
          begin
            doe_n_q <= 1'b0;
            state_q <= ST_PSET;
          end
        end
        ST_SUPDN:
        begin
          pins_q.chip_sel_n <= 1'b1;
          sup_q             <= EPRC_SUP_READ;
          if (tdone)
          begin
            pins_q.addr <= '0;
            state_q     <= ST_FIN;
            pulsed_q    <= 1'b0;
          end
        end
        ST_FIN:
        begin
          // Final read-back compare at read supplies, unless already failed.
          if (fail_q || pins_q.chip_sel_n == 1'b0 && tdone && pins_q.addr == LAST_ADDR
              && !pulsed_q)
          begin
            pins_q.chip_sel_n <= 1'b1;
            pins_q.gate_n     <= 1'b1;
            doe_n_q           <= 1'b1;
            sup_q             <= EPRC_SUP_READ;
            rsp_valid_q       <= 1'b1;
            if (!fail_q && data_in_i != src_data_i)
              fail_q <= 1'b1;
            state_q <= ST_IDLE;
          end
          else if (pins_q.chip_sel_n)
          begin
            pins_q.chip_sel_n <= 1'b0;
            pins_q.gate_n     <= 1'b0;
            pulsed_q          <= 1'b1;
          end
          else if (pulsed_q)
            pulsed_q <= 1'b0;
          else if (tdone)
          begin
            if (data_in_i != src_data_i)
              fail_q <= 1'b1;
            pins_q.addr <= pins_q.addr + 1'b1;
            pulsed_q    <= 1'b1;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign req_ready_o        = (state_q == ST_IDLE);
  assign rsp_valid_o        = rsp_valid_q;
  assign rsp_data_o         = rsp_data_q;
  assign rsp_fail_o         = fail_q;
  assign src_addr_o         = pins_q.addr;
  assign mem_addr_o         = pins_q.addr | (AW'(pins_q.id_high_volt) << ID_LINE_BIT);
  assign chip_sel_n_o       = pins_q.chip_sel_n;
  assign gate_n_o           = pins_q.gate_n;
  assign program_strobe_n_o = pins_q.program_strobe_n;
  assign id_high_volt_o     = pins_q.id_high_volt;
  assign supply_o           = sup_q;
  assign data_out_o         = dout_q;
  assign data_oe_n_o        = doe_n_q;

endmodule : eprc_ctrl

// ### eprc_mem_model.sv
// Behavioural model of the byte-wide programmable memory seen by the controller.
module eprc_mem_model
  import eprc_pkg::*;
#(
  parameter real        ACC_NS   = 240.0,  // Address and select access time.
  parameter real        OE_NS    = 90.0,   // Gate access time.
  parameter logic [7:0] MAKER_ID = 8'h5A,  // Arbitrary value.
  parameter logic [7:0] DEV_ID   = 8'hC3   // Arbitrary value.
)
(
  input  wire eprc_pkg::eprc_pins_t pins_i,   // Control and address lines.
  input  wire eprc_pkg::eprc_sup_t  supply_i, // Supply level.
  input  wire logic [7:0]           din_i,    // Data lines as seen.
  input  wire logic                 erase_i,  // Erase every byte.
  input  wire logic [3:0]           need_i,   // Pulses location 1 needs.
  output logic [7:0]                dout_o,   // Data driven by the memory.
  output int                        viol_o    // Pulses under wrong pins.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [4];
  int         hits [4];
  real        a_t, c_t, g_t, f_t;
  logic       drive;
  logic [7:0] word;
  ////////////////////////////////////////////////////////////////
  assign drive = !pins_i.chip_sel_n && !pins_i.gate_n;
  assign word  = pins_i.id_high_volt ? (pins_i.addr[0] ? DEV_ID : MAKER_ID) : mem[pins_i.addr[1:0]];
  initial
  begin
    dout_o = 8'h00;
    viol_o = 0;
    f_t    = 0.0;
  end
  always @(pins_i.addr) a_t = $realtime;
  always @(pins_i.chip_sel_n) c_t = $realtime;
  always @(pins_i.gate_n) g_t = $realtime;
  always @(negedge pins_i.program_strobe_n) f_t = $realtime;
  // Invalid or released lines toggle so that a stale value is never mistaken for data.
  always #5
    if (drive && $realtime - a_t >= ACC_NS && $realtime - c_t >= ACC_NS && $realtime - g_t >= OE_NS)
      dout_o = word;
    else
      dout_o = ~dout_o;
  ////////////////////////////////////////////////////////////////
  // Location 1 holds back until it has seen need_i pulses, to force retries.
  always @(posedge pins_i.program_strobe_n or posedge erase_i)
    if (erase_i)
    begin
      mem  = '{default: 8'hFF};
      hits = '{default: 0};
    end
    else if (f_t > 0.0)
    begin
      if (!pins_i.chip_sel_n && pins_i.gate_n && supply_i == EPRC_SUP_PROG)
      begin
        hits[pins_i.addr[1:0]]++;
        if (pins_i.addr[1:0] != 2'd1 || hits[1] >= need_i)
          mem[pins_i.addr[1:0]] &= din_i;
      end
      else
        viol_o++;
    end
endmodule : eprc_mem_model

// ### eprc_ctrl_chk.sv
// Concurrent checks on the pins of the memory programmer controller.
module eprc_ctrl_chk
  import eprc_pkg::*;
#(
  parameter int unsigned   PULSE_CYCLES = PULSE_CYC,
  parameter int unsigned   AW           = ADDR_W,
  parameter logic [AW-1:0] LAST_ADDR    = '1
)
(
  input wire logic                mclk_i,             // Clock.
  input wire logic                reset_i,            // Reset.
  input wire logic                req_ready_o,        // Idle.
  input wire logic                rsp_valid_o,        // Answer pulse.
  input wire logic [AW-1:0]       mem_addr_o,         // Address lines.
  input wire logic                chip_sel_n_o,       // Chip select.
  input wire logic                gate_n_o,           // Output gate.
  input wire logic                program_strobe_n_o, // Strobe.
  input wire logic                id_high_volt_o,     // Id voltage.
  input wire eprc_pkg::eprc_sup_t supply_o,           // Supply level.
  input wire logic [DATA_W-1:0]   data_out_o,         // Driven data.
  input wire logic                data_oe_n_o         // Drive enable.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] lo_q;
  logic [15:0] g_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i)
    if (reset_i || program_strobe_n_o) lo_q <= '0;
    else lo_q <= lo_q + 16'h0001;
  always_ff @(posedge mclk_i)
    if (reset_i || chip_sel_n_o || gate_n_o) g_q <= '0;
    else g_q <= g_q + 16'h0001;
  ////////////////////////////////////////////////////////////////
  // The pulse is judged against the tolerance band, not one exact count.
  a_pulse_width: assert property ($rose(program_strobe_n_o) |->
    lo_q >= PULSE_CYCLES * PULSE_MIN_US / PULSE_NOM_US && lo_q <= PULSE_CYCLES * PULSE_MAX_US / PULSE_NOM_US)
    else $error("program pulse width wrong");
  a_pulse_pins: assert property (!program_strobe_n_o |->
    !chip_sel_n_o && gate_n_o && !data_oe_n_o && supply_o == EPRC_SUP_PROG)
    else $error("pins wrong during program pulse");
  a_pulse_stable: assert property (!program_strobe_n_o && !$past(program_strobe_n_o) |->
    $stable(mem_addr_o) && $stable(data_out_o))
    else $error("address or data moved in pulse");
  a_supply_order: assert property (supply_o == EPRC_SUP_PROG |-> $past(supply_o) != EPRC_SUP_READ)
    else $error("programming supply before core");
  a_no_clash: assert property (!data_oe_n_o |-> gate_n_o)
    else $error("driving data with gate low");
  a_float_wait: assert property ($rose(gate_n_o) |-> data_oe_n_o [*6])
    else $error("data driven inside float time");
  a_read_access: assert property ($rose(gate_n_o) && supply_o == EPRC_SUP_READ |-> g_q >= ACCESS_CYC)
    else $error("read ended before access time");
  a_verify_wait: assert property ($rose(gate_n_o) && supply_o == EPRC_SUP_PROG |-> g_q >= GATE_ACCESS_CYC)
    else $error("verify ended before gate access");
  a_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("answer pulse longer than one cycle");
  a_idle_pins: assert property (req_ready_o |->
    chip_sel_n_o && program_strobe_n_o && data_oe_n_o && supply_o == EPRC_SUP_READ)
    else $error("pins active while idle");
  a_id_lines: assert property (id_high_volt_o && !chip_sel_n_o |->
    mem_addr_o[AW-1:1] == (AW-1)'(1 << (ID_LINE_BIT - 1)))
    else $error("address lines wrong in identify");
endmodule : eprc_ctrl_chk

bind eprc_ctrl eprc_ctrl_chk #(.PULSE_CYCLES(PULSE_CYCLES), .AW(AW), .LAST_ADDR(LAST_ADDR)) u_chk
  (.mclk_i(mclk_i), .reset_i(reset_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
   .mem_addr_o(mem_addr_o), .chip_sel_n_o(chip_sel_n_o), .gate_n_o(gate_n_o),
   .program_strobe_n_o(program_strobe_n_o), .id_high_volt_o(id_high_volt_o), .supply_o(supply_o),
   .data_out_o(data_out_o), .data_oe_n_o(data_oe_n_o));

// ### tb_eprc_ctrl.sv
// Self-checking testbench of the memory programmer controller.
module tb_eprc_ctrl
  import eprc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
  localparam logic [7:0] DEVT  = 8'hC3; // Arbitrary value.
  logic       mclk, reset, req_valid, rdy, rsp_valid, rsp_fail, cs_n, gate_n, strobe_n, idv, oe_n, erase;
  eprc_op_t   op;
  eprc_sup_t  sup;
  logic [17:0] req_addr, src_addr, mem_addr;
  logic [7:0] rsp_data, src_data, dout, mdout, bus;
  logic [7:0] src [4] = '{8'h3C, 8'hA5, 8'h00, 8'h7E};
  logic [3:0] need;
  int         err_count, checked, pulses, cyc, viol;
  ////////////////////////////////////////////////////////////////
  assign src_data = src[src_addr[1:0]];
  assign bus      = oe_n ? mdout : dout;
  eprc_ctrl #(.PULSE_CYCLES(40), .AW(18), .LAST_ADDR(18'h00003)) DUT
    (.mclk_i(mclk), .reset_i(reset), .req_valid_i(req_valid), .req_op_i(op), .req_addr_i(req_addr),
     .req_ready_o(rdy), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_fail_o(rsp_fail),
     .src_addr_o(src_addr), .src_data_i(src_data), .mem_addr_o(mem_addr), .chip_sel_n_o(cs_n),
     .gate_n_o(gate_n), .program_strobe_n_o(strobe_n), .id_high_volt_o(idv), .supply_o(sup),
     .data_in_i(bus), .data_out_o(dout), .data_oe_n_o(oe_n));
  eprc_mem_model #(.MAKER_ID(MAKER), .DEV_ID(DEVT)) u_mem
    (.pins_i({cs_n, gate_n, strobe_n, idv, mem_addr}), .supply_i(sup), .din_i(bus), .erase_i(erase),
     .need_i(need), .dout_o(mdout), .viol_o(viol));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  always @(negedge strobe_n) pulses++;
  ////////////////////////////////////////////////////////////////
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk_byte
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_byte(n, {7'h00, e}, {7'h00, g});
  endtask : chk_bit
  task automatic chk_num(input string n, input int e, input int g);
    checked++;
    if (g != e)
    begin
      err_count++;
      $display("unexpected %s exp %0d got %0d", n, e, g);
    end
  endtask : chk_num
  // One request, raised for one cycle after a bounded wait for ready, then a bounded wait for the answer.
  task automatic req(input eprc_op_t o, input logic [17:0] a);
    int n = 0;
    while (rdy !== 1'b1 && n < 50)
    begin
      @(posedge mclk) #1 n++;
    end
    op = o;
    req_addr = a;
    req_valid = 1'b1;
    @(posedge mclk) #1 req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 6000)
    begin
      @(posedge mclk) #1 n++;
    end
    chk_bit("answer", 1'b1, rsp_valid);
  endtask : req
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_bit("ready", 1'b1, rdy);
    chk_bit("chip select", 1'b1, cs_n);
    chk_bit("strobe", 1'b1, strobe_n);
    chk_bit("drive enable", 1'b1, oe_n);
    chk_byte("supply", {6'h00, EPRC_SUP_READ}, {6'h00, sup});
  endtask : t_reset
  task automatic t_id();
    req(EPRC_OP_ID, 18'h00000);
    chk_byte("maker byte", MAKER, rsp_data);
    req(EPRC_OP_ID, 18'h00001);
    chk_byte("device byte", DEVT, rsp_data);
  endtask : t_id
  // Location 1 resists nd-1 pulses; a clean run ends in read mode with source data.
  task automatic t_prog(input logic [3:0] nd, input logic fl, input int np);
    erase = 1'b1;
    @(posedge mclk) #1 erase = 1'b0;
    need = nd;
    pulses = 0;
    req(EPRC_OP_PROG, 18'h00000);
    chk_bit("fail flag", fl, rsp_fail);
    chk_num("pulse count", np, pulses);
    chk_byte("supply", {6'h00, EPRC_SUP_READ}, {6'h00, sup});
    chk_num("bad pulses", 0, viol);
    for (int a = 0; a < 4 && !fl; a++)
    begin
      req(EPRC_OP_READ, 18'(a));
      chk_byte("read byte", src[a], rsp_data);
    end
  endtask : t_prog
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial
  begin
    reset = 1'b1;
    req_valid = 1'b0;
    op = EPRC_OP_READ;
    req_addr = '0;
    erase = 1'b0;
    need = 4'h1;
    err_count = 0;
    checked = 0;
    pulses = 0;
    cyc = 0;
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    t_reset();
    t_id();
    t_prog(4'h2, 1'b0, 5);
    t_prog(4'hB, 1'b0, 14);
    t_prog(4'hC, 1'b1, 14);
    t_id();
    finish_test();
  end
endmodule : tb_eprc_ctrl
